// ==== rtl/psram_pkg.sv ====
// Constants and carrier types for the muxed-bus pseudo-static memory
package psram_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int ROW_W = 7;
    localparam int ROWS_W = ADDR_W - ROW_W;
    localparam int CLK_MHZ = 20;
    // Configuration register reset values and field positions
    localparam logic [15:0] BUS_CFG_RESET = 16'h981F;
    localparam logic [15:0] REF_CFG_RESET = 16'h0010;
    localparam int BUS_MODE_BIT = 15;
    localparam int BUS_FIXED_LAT_BIT = 14;
    localparam int BUS_LAT_LSB = 11;
    localparam int BUS_WAIT_POL_BIT = 10;
    localparam int BUS_DRIVE_LSB = 4;
    localparam int BUS_NOWRAP_BIT = 3;
    localparam int REF_AWAKE_BIT = 4;
    // Burst length and partial refresh codes
    localparam logic [2:0] BURST_4 = 3'h1;
    localparam logic [2:0] BURST_8 = 3'h2;
    localparam logic [2:0] BURST_16 = 3'h3;
    localparam logic [2:0] BURST_CONT = 3'h7;
    localparam logic [2:0] SUBSET_NONE = 3'h4;
    // Register select in the top two address bits
    localparam logic [1:0] SEL_REFRESH = 2'h0;
    localparam logic [1:0] SEL_ID = 2'h1;
    localparam logic [1:0] SEL_BUS = 2'h2;
    // Refresh timing
    localparam int REFRESH_HOT_NS = 15600;
    localparam int REFRESH_COOL_NS = 62400;
    localparam int REFRESH_BUSY_NS = 100;
    localparam int REFRESH_HOT_CYC = REFRESH_HOT_NS * CLK_MHZ / 1000;
    localparam int REFRESH_COOL_CYC = REFRESH_COOL_NS * CLK_MHZ / 1000;
    localparam int REFRESH_BUSY_CYC = (REFRESH_BUSY_NS * CLK_MHZ + 999) / 1000;
    typedef enum logic [2:0] {IDLE, ASYNC, LATENCY, BURST, ROWEND} phase_t;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [1:0] lanes;
    } wr_entry_t;
endpackage

// ==== rtl/write_fifo.sv ====
// Write data FIFO between the bus and the memory array
module write_fifo #(
    parameter int WIDTH = 38,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } fifo_state_t;
    fifo_state_t s, n;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;
    // Flags and handshakes
    assign in_ready_o = s.cnt != (PW+1)'(DEPTH);
    assign out_valid_o = s.cnt != '0;
    assign out_data_o = mem[s.rp];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    // Pointer and count update
    always_comb begin
        n = s;
        if (push) n.wp = s.wp + 1'b1;
        if (pop) n.rp = s.rp + 1'b1;
        if (push && !pop) n.cnt = s.cnt + 1'b1;
        if (pop && !push) n.cnt = s.cnt - 1'b1;
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) s <= '0;
        else s <= n;
        if (push) mem[s.wp] <= in_data_i;
    end
endmodule

// ==== rtl/psram_bus_interface.sv ====
// Muxed address/data bus front end of a self-refreshing 1M x 16 memory
module psram_bus_interface #(
    parameter logic [15:0] DEVICE_ID = 16'h0A5A, // Arbitrary identity value
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Bus control
    input wire logic bus_clk_i,
    input wire logic chip_select_n_i,
    input wire logic output_enable_n_i,
    input wire logic write_enable_n_i,
    input wire logic address_valid_n_i,
    input wire logic register_space_select_i,
    input wire logic low_byte_select_n_i,
    input wire logic high_byte_select_n_i,
    // Address and data lines
    input wire logic [3:0] upper_address_lines_i,
    input wire logic [15:0] shared_addr_data_lines_i,
    output logic [15:0] shared_addr_data_lines_o,
    output logic [1:0] shared_addr_data_lines_oe_n_o,
    // Wait pin
    output logic wait_o,
    output logic wait_oe_n_o,
    // Sensing and status
    input wire logic temp_cool_i,
    output logic [1:0] drive_strength_o,
    output logic deep_sleep_o,
    output logic refresh_active_o
);
    localparam int EW = $bits(psram_pkg::wr_entry_t);
    typedef struct packed {
        psram_pkg::phase_t phase;
        logic bclk_q;
        logic adv_q;
        logic we_q;
        logic cs_q;
        logic [19:0] addr;
        logic reg_sp;
        logic is_write;
        logic [3:0] lat_cnt;
        logic [4:0] beats;
        logic [15:0] bus_cfg;
        logic [15:0] ref_cfg;
        logic deep;
        logic [12:0] ref_row;
        logic [10:0] ref_timer;
        logic [1:0] ref_busy;
        logic [15:0] dq_out;
        logic [1:0] dq_oe_n;
        logic wait_pin;
        logic wait_oe_n;
        logic [1:0] drive;
        logic ref_act;
    } state_t;
    state_t s, n;
    logic [15:0] mem [2**psram_pkg::ADDR_W];
    logic cs_n, bclk_rise, adv_rise, we_rise, cs_rise, cs_fall;
    logic sync_mode, wrap, stall, stall_next, refreshing, wait_act, read_drive;
    logic fin_ready, fout_valid, fout_ready, push;
    logic [1:0] lanes;
    logic [4:0] burst_len;
    logic [19:0] mask, next_addr;
    logic [13:0] row_limit;
    logic [12:0] next_row;
    logic [10:0] interval;
    logic [15:0] reg_word, rd_word;
    logic [3:0] lat;
    psram_pkg::wr_entry_t push_e, pop_e;

    // Edge detection on sampled bus pins
    assign cs_n = chip_select_n_i;
    assign bclk_rise = bus_clk_i && !s.bclk_q;
    assign adv_rise = address_valid_n_i && !s.adv_q;
    assign we_rise = write_enable_n_i && !s.we_q;
    assign cs_rise = cs_n && !s.cs_q;
    assign cs_fall = !cs_n && s.cs_q;
    assign lanes = ~{high_byte_select_n_i, low_byte_select_n_i};

    // Mode decode from the bus configuration
    assign sync_mode = !s.bus_cfg[psram_pkg::BUS_MODE_BIT];
    assign lat = {1'b0, s.bus_cfg[psram_pkg::BUS_LAT_LSB +: 3]};
    always_comb begin
        unique case (s.bus_cfg[2:0])
            psram_pkg::BURST_4: burst_len = 5'h04;
            psram_pkg::BURST_8: burst_len = 5'h08;
            psram_pkg::BURST_16: burst_len = 5'h10;
            default: burst_len = 5'h00;
        endcase
    end
    assign wrap = !s.bus_cfg[psram_pkg::BUS_NOWRAP_BIT] && burst_len != 5'h00;
    assign mask = {15'h0000, burst_len - 5'h01};
    assign next_addr = wrap ? ((s.addr & ~mask) | ((s.addr + 20'h00001) & mask)) : s.addr + 20'h00001;

    // Array busy: refresh in progress, a full write FIFO during a write, or writes still queued ahead of a read
    assign refreshing = s.ref_busy != 2'h0;
    assign stall = refreshing || (s.is_write ? !fin_ready : fout_valid);

    // Register and array read data
    always_comb begin
        unique case (s.addr[19:18])
            psram_pkg::SEL_REFRESH: reg_word = s.ref_cfg;
            psram_pkg::SEL_BUS: reg_word = s.bus_cfg;
            psram_pkg::SEL_ID: reg_word = DEVICE_ID;
            default: reg_word = 16'h0000;
        endcase
    end
    assign rd_word = s.reg_sp ? reg_word : mem[s.addr];

    // Refresh region and rate
    assign row_limit = s.ref_cfg[2:0] >= psram_pkg::SUBSET_NONE ? 14'h0000 :
        14'(15'h2000 >> s.ref_cfg[1:0]);
    assign next_row = ({1'b0, s.ref_row} + 14'h0001 >= row_limit) ? 13'h0000 : s.ref_row + 13'h0001;
    assign interval = temp_cool_i ? 11'(psram_pkg::REFRESH_COOL_CYC - 1) :
        11'(psram_pkg::REFRESH_HOT_CYC - 1);

    // Array writes enter the FIFO; async writes, burst write beats
    assign push = !s.reg_sp && !cs_n && ((s.phase == psram_pkg::ASYNC && we_rise) ||
        (s.phase == psram_pkg::BURST && s.is_write && bclk_rise && !stall));
    assign push_e = '{addr: s.addr, data: shared_addr_data_lines_i, lanes: lanes};
    assign fout_ready = !refreshing;

    write_fifo #(.WIDTH(EW), .DEPTH(FIFO_DEPTH)) write_fifo_inst (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .in_valid_i(push),
        .in_ready_o(fin_ready),
        .in_data_i(push_e),
        .out_valid_o(fout_valid),
        .out_ready_i(fout_ready),
        .out_data_o(pop_e)
    );

    // Drain queued words into the array with byte lanes
    always_ff @(posedge clk_i) begin
        if (fout_valid && fout_ready) begin
            if (pop_e.lanes[0]) mem[pop_e.addr][7:0] <= pop_e.data[7:0];
            if (pop_e.lanes[1]) mem[pop_e.addr][15:8] <= pop_e.data[15:8];
        end
    end

    // Next state: refresh, deep sleep, bus phases and pins
    always_comb begin
        n = s;
        n.bclk_q = bus_clk_i;
        n.adv_q = address_valid_n_i;
        n.we_q = write_enable_n_i;
        n.cs_q = cs_n;
        // Hidden refresh timer
        if (refreshing) n.ref_busy = s.ref_busy - 2'h1;
        if (s.deep) begin
            n.ref_timer = interval;
        end else if (s.ref_timer == 11'h000) begin
            n.ref_timer = interval;
            if (row_limit != 14'h0000) begin
                n.ref_busy = 2'(psram_pkg::REFRESH_BUSY_CYC);
                n.ref_row = next_row;
            end
        end else begin
            n.ref_timer = s.ref_timer - 11'h001;
        end
        // Deep sleep entry and exit
        if (cs_rise && !s.ref_cfg[psram_pkg::REF_AWAKE_BIT]) n.deep = 1'b1;
        if (cs_fall && s.deep) begin
            n.deep = 1'b0;
            n.ref_cfg = psram_pkg::REF_CFG_RESET;
        end
        // Register writes, taken on the same strobes as array writes
        if (s.reg_sp && !cs_n && ((s.phase == psram_pkg::ASYNC && we_rise) ||
            (s.phase == psram_pkg::BURST && s.is_write && bclk_rise && !stall))) begin
            if (s.addr[19:18] == psram_pkg::SEL_BUS) n.bus_cfg = shared_addr_data_lines_i;
            if (s.addr[19:18] == psram_pkg::SEL_REFRESH) n.ref_cfg = shared_addr_data_lines_i;
        end
        unique case (s.phase)
            psram_pkg::IDLE, psram_pkg::ASYNC: begin
                if (!cs_n && !s.deep && adv_rise && !bus_clk_i) begin
                    n.addr = {upper_address_lines_i, shared_addr_data_lines_i};
                    n.reg_sp = register_space_select_i;
                    n.phase = psram_pkg::ASYNC;
                end else if (!cs_n && !s.deep && bclk_rise && !address_valid_n_i && sync_mode) begin
                    n.addr = {upper_address_lines_i, shared_addr_data_lines_i};
                    n.reg_sp = register_space_select_i;
                    n.is_write = !write_enable_n_i;
                    n.lat_cnt = lat == 4'h0 ? 4'h1 : lat;
                    n.beats = 5'h00;
                    n.phase = psram_pkg::LATENCY;
                end
            end
            psram_pkg::LATENCY: begin
                // Fixed latency counts every edge; variable latency holds while busy
                if (bclk_rise && (s.bus_cfg[psram_pkg::BUS_FIXED_LAT_BIT] || !stall)) begin
                    n.lat_cnt = s.lat_cnt - 4'h1;
                    if (s.lat_cnt == 4'h1) n.phase = psram_pkg::BURST;
                end
            end
            psram_pkg::BURST: begin
                if (bclk_rise && !stall) begin
                    n.beats = s.beats + 5'h01;
                    n.addr = next_addr;
                    if (s.reg_sp || (burst_len != 5'h00 && !wrap && s.beats + 5'h01 == burst_len)) begin
                        n.phase = psram_pkg::IDLE;
                    end else if (&s.addr[psram_pkg::ROW_W-1:0] && !wrap) begin
                        n.phase = psram_pkg::ROWEND;
                    end
                end
            end
            psram_pkg::ROWEND: begin
                if (bclk_rise) n.phase = psram_pkg::BURST;
            end
        endcase
        if (cs_n) n.phase = psram_pkg::IDLE;
        // Output pins
        n.dq_out = rd_word;
        read_drive = !cs_n && !output_enable_n_i && write_enable_n_i && (s.phase == psram_pkg::ASYNC ||
            (s.phase == psram_pkg::BURST && !s.is_write));
        n.dq_oe_n = read_drive ? ~lanes : 2'b11;
        // Burst wait shows the stall that the next bus clock rise meets, so host and array agree
        stall_next = n.ref_busy != 2'h0 || (s.is_write ? !fin_ready : fout_valid);
        wait_act = s.phase == psram_pkg::LATENCY || s.phase == psram_pkg::ROWEND ||
            s.phase == psram_pkg::ASYNC || (s.phase == psram_pkg::BURST && stall_next);
        n.wait_pin = wait_act ^ !s.bus_cfg[psram_pkg::BUS_WAIT_POL_BIT];
        n.wait_oe_n = cs_n;
        n.drive = s.bus_cfg[psram_pkg::BUS_DRIVE_LSB +: 2];
        n.ref_act = refreshing;
    end

    // State register with power-up defaults
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s <= '0;
            s.phase <= psram_pkg::IDLE;
            s.bclk_q <= 1'b0;
            s.adv_q <= 1'b1;
            s.we_q <= 1'b1;
            s.cs_q <= 1'b1;
            s.bus_cfg <= psram_pkg::BUS_CFG_RESET;
            s.ref_cfg <= psram_pkg::REF_CFG_RESET;
            s.dq_oe_n <= 2'b11;
            s.wait_oe_n <= 1'b1;
            s.drive <= psram_pkg::BUS_CFG_RESET[psram_pkg::BUS_DRIVE_LSB +: 2];
        end else begin
            s <= n;
        end
    end

    assign shared_addr_data_lines_o = s.dq_out;
    assign shared_addr_data_lines_oe_n_o = s.dq_oe_n;
    assign wait_o = s.wait_pin;
    assign wait_oe_n_o = s.wait_oe_n;
    assign drive_strength_o = s.drive;
    assign deep_sleep_o = s.deep;
    assign refresh_active_o = s.ref_act;

    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // Wait pin released one cycle after deselect
    wait_release_a: assert property (cs_n |=> wait_oe_n_o) else $error("wait driven while deselected");
    // Wait pin driven one cycle after select
    wait_drive_a: assert property (!cs_n |=> !wait_oe_n_o) else $error("wait released while selected");
    // Deep sleep entered on select rise with awake bit clear
    deep_entry_a: assert property (cs_rise && !s.ref_cfg[psram_pkg::REF_AWAKE_BIT] |=> deep_sleep_o)
        else $error("deep sleep not entered");
    // No refresh once deep sleep has settled
    deep_norefresh_a: assert property (deep_sleep_o [*4] |-> !refresh_active_o)
        else $error("refresh running in deep sleep");
    // Async address latched from the lines at address-valid rise
    async_addr_a: assert property (s.phase == psram_pkg::IDLE && !cs_n && !s.deep && adv_rise && !bus_clk_i
        |=> s.addr == {$past(upper_address_lines_i), $past(shared_addr_data_lines_i)})
        else $error("async address wrong");
    // Sync address latched at first clock rise with address valid low
    sync_addr_a: assert property (s.phase == psram_pkg::IDLE && !cs_n && !s.deep && bclk_rise &&
        !address_valid_n_i && sync_mode && address_valid_n_i == s.adv_q |=> s.phase == psram_pkg::LATENCY &&
        s.addr == {$past(upper_address_lines_i), $past(shared_addr_data_lines_i)})
        else $error("sync address wrong");
    // Wait shows active level during async access
    async_wait_a: assert property (s.phase == psram_pkg::ASYNC && !cs_n
        |=> wait_o == $past(s.bus_cfg[psram_pkg::BUS_WAIT_POL_BIT])) else $error("async wait level wrong");
    // Row end inserts an active wait
    row_end_a: assert property (s.phase == psram_pkg::ROWEND && !cs_n
        |=> wait_o == $past(s.bus_cfg[psram_pkg::BUS_WAIT_POL_BIT])) else $error("row end wait missing");
    // Refresh collision stalls the burst
    refresh_stall_a: assert property (s.phase == psram_pkg::BURST && refreshing && !cs_n
        |-> wait_o == $past(s.bus_cfg[psram_pkg::BUS_WAIT_POL_BIT]) ##1 s.addr == $past(s.addr))
        else $error("burst not stalled by refresh");
    // Low lane driven only where its byte select was low
    lane_drive_a: assert property (!shared_addr_data_lines_oe_n_o[0] |-> !$past(low_byte_select_n_i))
        else $error("low lane driven unselected");
endmodule

// ==== verif/psram_host_model.sv ====
// Host controller model that drives the muxed bus of the memory
module psram_host_model (
    // Clock
    input wire logic clk_i,
    // Bus pins toward the memory
    output logic bclk_o,
    output logic cs_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    output logic adv_n_o,
    output logic rs_o,
    output logic [1:0] lanes_n_o,
    output logic [3:0] upper_o,
    output logic [15:0] lines_o,
    // Pins driven by the memory
    input wire logic [15:0] dq_i,
    input wire logic [1:0] dq_oe_n_i,
    input wire logic wait_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] h_val;
    // A lane the memory leaves shows the host value, a lane it drives shows its data
    assign lines_o = {dq_oe_n_i[1] ? h_val[15:8] : dq_i[15:8], dq_oe_n_i[0] ? h_val[7:0] : dq_i[7:0]};
    // Idle bus, burst clock low
    initial begin
        {cs_n_o, oe_n_o, we_n_o, adv_n_o} = 4'hF;
        bclk_o = 1'b0;
        {rs_o, lanes_n_o, upper_o, h_val} = 23'h0;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #5;
    endtask
    // Address phase, latched as address valid rises
    task automatic latch(input logic [19:0] a, input logic rs);
        {cs_n_o, adv_n_o, rs_o} = {2'h0, rs};
        {upper_o, h_val} = a;
        cyc(2);
        adv_n_o = 1'b1;
        cyc(2);
        rs_o = 1'b0;
    endtask
    task automatic write(input logic [19:0] a, input logic rs, input logic [15:0] d, input logic [1:0] ln);
        latch(a, rs);
        {h_val, lanes_n_o, we_n_o} = {d, ln, 1'b0};
        cyc(2);
        we_n_o = 1'b1;
        cyc(2);
        {h_val, lanes_n_o} = {~h_val, 2'h0};
        cs_n_o = 1'b1;
        cyc(2);
    endtask
    task automatic read(input logic [19:0] a, input logic rs, input logic [1:0] ln,
                        output logic [15:0] d, output logic [1:0] oe, output logic wt);
        latch(a, rs);
        {h_val, lanes_n_o, oe_n_o} = {~h_val, ln, 1'b0};
        cyc(4);
        {d, oe, wt} = {lines_o, dq_oe_n_i, wait_i};
        {oe_n_o, cs_n_o, lanes_n_o} = 4'hC;
        cyc(2);
    endtask
    // Burst read: a word counts at a rise only while wait is inactive
    task automatic burst(input logic [19:0] a, input int n, input logic act,
                         output logic [15:0] q [16], output int stalls);
        int k;
        int g;
        {k, g, stalls} = 96'h0;
        {cs_n_o, adv_n_o, upper_o, h_val} = {2'h0, a};
        cyc(3);
        bclk_o = 1'b1;
        cyc(3);
        {adv_n_o, oe_n_o, bclk_o, h_val} = {3'h4, ~h_val};
        cyc(3);
        while (k < n && g < 80) begin
            if (wait_i !== act) begin
                q[k] = lines_o;
                k++;
            end else if (k > 0) begin
                stalls++;
            end
            bclk_o = 1'b1;
            cyc(3);
            bclk_o = 1'b0;
            cyc(3);
            g++;
        end
        {oe_n_o, cs_n_o} = 2'h3;
        cyc(3);
    endtask
endmodule

// ==== verif/psram_bus_interface_tb.sv ====
// Self-checking bench for the muxed-bus memory front end
module psram_bus_interface_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] TEST_ID = 16'h3C69; // Arbitrary identity value
    localparam logic [19:0] BASE = 20'h5A370;
    localparam logic [19:0] BUS_REG = {psram_pkg::SEL_BUS, 18'h0};
    localparam logic [19:0] REF_REG = {psram_pkg::SEL_REFRESH, 18'h0};
    logic clk_i, reset_i, temp_cool_i, bus_clk_i, chip_select_n_i, output_enable_n_i;
    logic write_enable_n_i, address_valid_n_i, register_space_select_i, low_byte_select_n_i;
    logic high_byte_select_n_i, wait_o, wait_oe_n_o, deep_sleep_o, refresh_active_o, wt, hit;
    logic [3:0] upper_address_lines_i;
    logic [15:0] shared_addr_data_lines_i, shared_addr_data_lines_o, rd;
    logic [1:0] shared_addr_data_lines_oe_n_o, drive_strength_o, oe;
    logic [15:0] exp_mem [20];
    logic [15:0] q [16];
    int failures, n_checks, stalls, gap;
    psram_bus_interface #(.DEVICE_ID(TEST_ID), .FIFO_DEPTH(16)) psram_bus_interface_inst (
        .clk_i, .reset_i, .bus_clk_i, .chip_select_n_i, .output_enable_n_i, .write_enable_n_i,
        .address_valid_n_i, .register_space_select_i, .low_byte_select_n_i, .high_byte_select_n_i,
        .upper_address_lines_i, .shared_addr_data_lines_i, .shared_addr_data_lines_o,
        .shared_addr_data_lines_oe_n_o, .wait_o, .wait_oe_n_o, .temp_cool_i, .drive_strength_o,
        .deep_sleep_o, .refresh_active_o);
    psram_host_model psram_host_model_inst (.clk_i(clk_i), .bclk_o(bus_clk_i), .cs_n_o(chip_select_n_i),
        .oe_n_o(output_enable_n_i), .we_n_o(write_enable_n_i), .adv_n_o(address_valid_n_i),
        .rs_o(register_space_select_i), .lanes_n_o({high_byte_select_n_i, low_byte_select_n_i}),
        .upper_o(upper_address_lines_i), .lines_o(shared_addr_data_lines_i),
        .dq_i(shared_addr_data_lines_o), .dq_oe_n_i(shared_addr_data_lines_oe_n_o), .wait_i(wait_o));
    // Clock at 50 ns
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic step();
        @(posedge clk_i);
        #5;
    endtask
    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Synchronous mode, latency three, wait active high, drive code 2
    function automatic logic [15:0] bus_cfg(input logic fixed, input logic [2:0] len);
        bus_cfg = {1'b0, fixed, 3'h3, 1'b1, 4'h0, 2'h2, 1'b1, len};
    endfunction
    // Cycles up to the next rise of refresh busy
    task automatic wait_rise(output int n);
        n = 0;
        while (refresh_active_o === 1'b1 && n < 3000) begin
            step();
            n++;
        end
        while (refresh_active_o !== 1'b1 && n < 3000) begin
            step();
            n++;
        end
        if (n >= 3000) failures++;
    endtask
    // Watchdog, several times the expected run
    initial begin
        #2000000;
        failures++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        {failures, n_checks, reset_i, temp_cool_i} = 66'h2;
        repeat (12) @(posedge clk_i);
        #5;
        reset_i = 1'b0;
        chk("drive reset", {14'h0, psram_pkg::BUS_CFG_RESET[5:4]}, {14'h0, drive_strength_o});
        chk("wait oe idle", 16'h1, {15'h0, wait_oe_n_o});
        chk("lines oe idle", 16'h3, {14'h0, shared_addr_data_lines_oe_n_o});
        step();
        psram_host_model_inst.read(REF_REG, 1'b1, 2'h0, rd, oe, wt);
        chk("refresh cfg", psram_pkg::REF_CFG_RESET, rd);
        psram_host_model_inst.read({psram_pkg::SEL_ID, 18'h0}, 1'b1, 2'h0, rd, oe, wt);
        chk("identity", TEST_ID, rd);
        psram_host_model_inst.read(BUS_REG, 1'b1, 2'h0, rd, oe, wt);
        chk("bus cfg", psram_pkg::BUS_CFG_RESET, rd);
        chk("async wait", {15'h0, psram_pkg::BUS_CFG_RESET[psram_pkg::BUS_WAIT_POL_BIT]}, {15'h0, wt});
        for (int i = 0; i < 20; i++) begin
            exp_mem[i] = 16'h1000 + 16'(i) * 16'h0111;
            psram_host_model_inst.write(BASE + 20'(i), 1'b0, exp_mem[i], 2'h0);
        end
        psram_host_model_inst.write(BASE ^ 20'h80000, 1'b0, 16'hDEAD, 2'h0);
        psram_host_model_inst.read(BASE + 20'h3, 1'b0, 2'h0, rd, oe, wt);
        chk("async read", exp_mem[3], rd);
        // Low lane only write, then low lane read
        psram_host_model_inst.write(BASE + 20'h1, 1'b0, 16'hEEEE, 2'h2);
        exp_mem[1][7:0] = 8'hEE;
        psram_host_model_inst.read(BASE + 20'h1, 1'b0, 2'h2, rd, oe, wt);
        chk("low lane oe", 16'h2, {14'h0, oe});
        chk("low lane", {8'h0, exp_mem[1][7:0]}, {8'h0, rd[7:0]});
        psram_host_model_inst.read(BASE + 20'h1, 1'b0, 2'h0, rd, oe, wt);
        chk("byte write", exp_mem[1], rd);
        // Fixed-length bursts, fixed latency on the middle one
        for (int c = 0; c < 3; c++) begin
            psram_host_model_inst.write(BUS_REG, 1'b1, bus_cfg(c == 1, c == 0 ? psram_pkg::BURST_4 :
                c == 1 ? psram_pkg::BURST_8 : psram_pkg::BURST_16), 2'h0);
            chk("drive", 16'h2, {14'h0, drive_strength_o});
            psram_host_model_inst.burst(BASE, 4 << c, 1'b1, q, stalls);
            for (int k = 0; k < (4 << c); k++) begin
                chk("burst word", exp_mem[k], q[k]);
            end
        end
        // Wrapping burst of four stays inside its aligned group
        psram_host_model_inst.write(BUS_REG, 1'b1, bus_cfg(1'b0, psram_pkg::BURST_4) & 16'hFFF7, 2'h0);
        psram_host_model_inst.burst(BASE + 20'h2, 4, 1'b1, q, stalls);
        for (int k = 0; k < 4; k++) begin
            chk("wrap word", exp_mem[(k + 2) % 4], q[k]);
        end
        // Continuous burst across the row end
        psram_host_model_inst.write(BUS_REG, 1'b1, bus_cfg(1'b0, psram_pkg::BURST_CONT), 2'h0);
        psram_host_model_inst.burst(BASE + 20'hE, 4, 1'b1, q, stalls);
        for (int k = 0; k < 4; k++) begin
            chk("row cross", exp_mem[14 + k], q[k]);
        end
        chk("row end stall", 16'h1, {15'h0, stalls > 0});
        psram_host_model_inst.read(BASE ^ 20'h80000, 1'b0, 2'h0, rd, oe, wt);
        chk("mixed read", 16'hDEAD, rd);
        chk("wait polarity", 16'h1, {15'h0, wt});
        // Refresh spacing hot and cool
        wait_rise(gap);
        wait_rise(gap);
        chk("hot gap", 16'(psram_pkg::REFRESH_HOT_CYC), 16'(gap));
        temp_cool_i = 1'b1;
        wait_rise(gap);
        wait_rise(gap);
        chk("cool gap", 16'(psram_pkg::REFRESH_COOL_CYC), 16'(gap));
        // Deep sleep entry on select rise, no refresh, exit on select fall
        psram_host_model_inst.write(REF_REG, 1'b1, 16'h0000, 2'h0);
        chk("deep entry", 16'h1, {15'h0, deep_sleep_o});
        // Let a refresh begun at the select rise run out first
        repeat (2) step();
        hit = 1'b0;
        repeat (1500) begin
            step();
            hit = hit | (refresh_active_o !== 1'b0);
        end
        chk("deep refresh", 16'h0, {15'h0, hit});
        psram_host_model_inst.read(REF_REG, 1'b1, 2'h0, rd, oe, wt);
        chk("deep exit", 16'h0, {15'h0, deep_sleep_o});
        chk("refresh cfg wake", psram_pkg::REF_CFG_RESET, rd);
        report_and_stop();
    end
endmodule
